/* logic/cpm_pkg.sv */
/*
  Package for the clock protect and main oscillator control block.
  Holds register offsets, field positions, reset values and divider sizes.
  Assumes a byte-wide register port with twelve address bits.
*/
package cpm_pkg;
  localparam int            ADDR_W          = 12;
  localparam int            DATA_W          = 8;
  localparam logic [11:0]   PRESCALER_OFS   = 12'h341;
  localparam logic [11:0]   PROTECT_OFS     = 12'h342;
  localparam logic [11:0]   OSC_CTRL_OFS    = 12'h343;
  localparam logic [11:0]   WPROT_OFS       = 12'h344;
  localparam int            PRESC_BIT       = 7;
  localparam int            LOCK_BIT        = 1;
  localparam int            WDT_SRC_BIT     = 2;
  localparam int            NMI_EN_BIT      = 4;
  localparam int            DIV_SRC_BIT     = 6;
  localparam int            WAIT_STOP_BIT   = 0;
  localparam int            MAIN_STOP_BIT   = 1;
  localparam int            PLL_EN_BIT      = 2;
  localparam int            OSD_EN_BIT      = 3;
  localparam int            WE_GRP1_BIT     = 1;
  localparam logic [7:0]    PROTECT_RST     = 8'h00;
  localparam logic [7:0]    OSC_CTRL_RST    = 8'h00;
  localparam logic [7:0]    PROTECT_WMASK   = 8'h56;
  localparam logic [7:0]    OSC_CTRL_WMASK  = 8'h0F;
  localparam logic [7:0]    ZERO_BYTE       = 8'h00;
  localparam int            PRESC_DIV       = 32;
  localparam int            PRESC_W         = 5;
  localparam int            SELF_OSC_DIV    = 12;
  localparam int            SELF_OSC_W      = 4;
endpackage

/* logic/cpm_div_if.sv */
/*
  Interface carrying a divider's clear request and its output tick.
  Assumes both ends run on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface cpm_div_if;
  logic clear;
  logic tick;
  modport ctrl (output clear, input tick);
  modport div  (input clear, output tick);
endinterface
`default_nettype wire

/* logic/cpm_divider.sv */
/*
  Counting divider that gives a one-cycle tick every DIV input edges.
  Assumes the clock enable is an ordinary synchronous input.
*/
`timescale 1ns/1ns
`default_nettype none
module cpm_divider #(
  parameter int DIV = 32,
  parameter int W   = 5
) (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic en_i,
  cpm_div_if.div    dv
);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  localparam logic [W-1:0] ONE  = W'(1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  wire          wrap = en_i && (cnt_q == LAST);

  assign cnt_d   = dv.clear ? '0 : (!en_i ? cnt_q : (wrap ? '0 : cnt_q + ONE));
  assign dv.tick = tick_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= wrap && !dv.clear;
    end
  end
endmodule
`default_nettype wire

/* logic/cpm_top.sv */
/*
  Clock protect and main oscillator control block.
  Assumes a single-cycle byte register port; clock gates are enables.
*/
// Operation
// - Prescaler reset clears sub clock divider; reads zero.
// - Prescaler low bits unstored; write zero.
// - Lock bit zero: protect register guards; one: locks.
// - Lock, watchdog source, NMI bits set-only.
// - Lock freezes wait stop, osc stop, PLL, detect.
// - Watchdog source: bus clock or on-chip oscillator.
// - Watchdog source one starts oscillator, no stop; code still halts it (oco_run_o) in stop mode.
// - NMI enable; zero also blocks motor cutoff.
// - Divided clock source: peripheral source or main.
// - Reset: main osc runs, PLL fed self-oscillation div12.
// - Oscillator stop drives output pin high.
// - Main clock feeds PLL, peripherals and CAN.
// - Stop mode halts every clock.
`timescale 1ns/1ns
`default_nettype none
module cpm_top (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rstn_i,
  input  wire logic [cpm_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [cpm_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  var  logic                        sub_clk_en_i,
  input  var  logic                        stop_mode_i,
  input  var  logic                        wait_mode_i,
  input  var  logic                        main_osc_input_pin_i,
  output logic [cpm_pkg::DATA_W-1:0]       rdata_o,
  output logic                             sub_div32_tick_o,
  output logic                             wdt_src_oco_o,
  output logic                             oco_run_o,
  output logic                             wdt_stop_block_o,
  output logic                             nmi_enable_o,
  output logic                             motor_cutoff_en_o,
  output logic                             div_clk_from_main_o,
  output logic                             main_osc_run_o,
  output logic                             main_osc_output_pin_o,
  output logic                             pll_ref_main_o,
  output logic                             cpu_self_osc_tick_o,
  output logic                             periph_clk_run_o,
  output logic                             main_clk_en_o,
  output logic                             can_clk_en_o
);
  import cpm_pkg::*;

  logic [7:0] protect_q;
  logic [7:0] protect_d;
  logic [7:0] osc_q;
  logic [7:0] osc_d;
  logic [7:0] wprot_q;
  logic [7:0] wprot_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       presc_clr_q;
  logic [14:0] outs_q;
  logic [14:0] outs_d;

  cpm_div_if sub_if ();
  cpm_div_if self_if ();

  wire sel_presc   = addr_i == PRESCALER_OFS;
  wire sel_protect = addr_i == PROTECT_OFS;
  wire sel_osc     = addr_i == OSC_CTRL_OFS;
  wire sel_wprot   = addr_i == WPROT_OFS;
  wire wr_presc    = wr_i && sel_presc;
  wire grp1_open   = wprot_q[WE_GRP1_BIT];
  wire locked      = protect_q[LOCK_BIT];
  // The protect register only moves while group 1 writes are open.
  wire wr_protect  = wr_i && sel_protect && grp1_open;
  // Oscillator control bits obey the same gate and are frozen by the lock.
  wire wr_osc      = wr_i && sel_osc && grp1_open && !locked;
  wire wr_wprot    = wr_i && sel_wprot;

  // Set-only bits: a written one sticks, a written zero is ignored.
  wire [7:0] sticky_mask = (8'h01 << LOCK_BIT) | (8'h01 << WDT_SRC_BIT) |
                           (8'h01 << NMI_EN_BIT);
  wire [7:0] prot_wr_val = wdata_i & PROTECT_WMASK;
  // Reserved bits never store, so a stray one written there is dropped.
  assign protect_d = wr_protect ?
    ((protect_q & sticky_mask) | prot_wr_val) : protect_q;
  assign osc_d     = wr_osc ? (wdata_i & OSC_CTRL_WMASK) : osc_q;
  assign wprot_d   = wr_wprot ? wdata_i : wprot_q;

  // Prescaler register holds no bits; it always reads as zero.
  wire [7:0] presc_rd = ZERO_BYTE;
  assign rdata_d = !rd_i ? ZERO_BYTE :
                   sel_presc   ? presc_rd :
                   sel_protect ? protect_q :
                   sel_osc     ? osc_q :
                   sel_wprot   ? wprot_q : ZERO_BYTE;

  // A reset bit write clears the sub clock divider next cycle.
  wire presc_clr_d = wr_presc && wdata_i[PRESC_BIT];
  assign sub_if.clear  = presc_clr_q;
  // Stop mode clears the self-oscillation count so nothing ticks.
  assign self_if.clear = stop_mode_i;

  cpm_divider #(.DIV(PRESC_DIV), .W(PRESC_W)) u_sub_div (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .en_i      (sub_clk_en_i && !stop_mode_i),
    .dv        (sub_if.div)
  );

  // After reset the CPU runs on self-oscillation divided by twelve.
  cpm_divider #(.DIV(SELF_OSC_DIV), .W(SELF_OSC_W)) u_self_div (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .en_i      (!osc_q[PLL_EN_BIT] && !stop_mode_i),
    .dv        (self_if.div)
  );

  wire wdt_oco    = protect_q[WDT_SRC_BIT];
  wire main_stop  = osc_q[MAIN_STOP_BIT];
  // Stop mode overrides software state and halts the main clock too.
  wire main_run   = !main_stop && !stop_mode_i;
  // Wait-mode stop halts the peripheral clock whatever the divided clock source.
  wire periph_run = !stop_mode_i &&
                    !(wait_mode_i && osc_q[WAIT_STOP_BIT]);

  assign outs_d = {
    sub_if.tick,                              // 14
    wdt_oco,                                  // 13
    wdt_oco && !stop_mode_i,                  // 12
    wdt_oco,                                  // 11
    protect_q[NMI_EN_BIT],                    // 10
    protect_q[NMI_EN_BIT],                    // 9
    protect_q[DIV_SRC_BIT],                   // 8
    main_run,                                 // 7
    main_stop ? 1'b1 : !main_osc_input_pin_i, // 6
    main_run && osc_q[PLL_EN_BIT],            // 5
    self_if.tick,                             // 4
    periph_run,                               // 3
    main_run,                                 // 2
    main_run,                                 // 1
    osc_q[OSD_EN_BIT]                         // 0
  };

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      protect_q   <= PROTECT_RST;
      osc_q       <= OSC_CTRL_RST;
      wprot_q     <= ZERO_BYTE;
      rdata_q     <= ZERO_BYTE;
      presc_clr_q <= 1'b0;
      outs_q      <= 15'h0000;
    end else begin
      protect_q   <= protect_d;
      osc_q       <= osc_d;
      wprot_q     <= wprot_d;
      rdata_q     <= rdata_d;
      presc_clr_q <= presc_clr_d;
      outs_q      <= outs_d;
    end
  end

  assign rdata_o               = rdata_q;
  assign sub_div32_tick_o      = outs_q[14];
  assign wdt_src_oco_o         = outs_q[13];
  assign oco_run_o             = outs_q[12];
  assign wdt_stop_block_o      = outs_q[11];
  assign nmi_enable_o          = outs_q[10];
  assign motor_cutoff_en_o     = outs_q[9];
  assign div_clk_from_main_o   = outs_q[8];
  assign main_osc_run_o        = outs_q[7];
  assign main_osc_output_pin_o = outs_q[6];
  assign pll_ref_main_o        = outs_q[5];
  assign cpu_self_osc_tick_o   = outs_q[4];
  assign periph_clk_run_o      = outs_q[3];
  assign main_clk_en_o         = outs_q[2];
  assign can_clk_en_o          = outs_q[1];

  chk_sticky_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(protect_q[LOCK_BIT]) |-> protect_q[LOCK_BIT])
    else $error("lock bit cleared");
  chk_wdt_sticky: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(protect_q[WDT_SRC_BIT]) |-> protect_q[WDT_SRC_BIT])
    else $error("watchdog source bit cleared");
  chk_osc_frozen: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $past(locked) |-> $stable(osc_q))
    else $error("oscillator bits changed while locked");
  chk_prot_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_i && sel_protect && !grp1_open) |=> $stable(protect_q))
    else $error("protect written while closed");
  chk_presc_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (rd_i && sel_presc) |=> (rdata_o == ZERO_BYTE))
    else $error("prescaler read not zero");
  sequence presc_clear_seq;
    presc_clr_q ##1 !sub_div32_tick_o;
  endsequence
  chk_presc_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    presc_clr_d |=> presc_clear_seq)
    else $error("divider clear had no effect");
  chk_main_osc_output_pin_high: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    main_stop |=> main_osc_output_pin_o && !main_osc_run_o)
    else $error("output pin not high");
  chk_nmi_follow: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 (nmi_enable_o == $past(protect_q[NMI_EN_BIT]) &&
         motor_cutoff_en_o == nmi_enable_o))
    else $error("nmi output mismatch");
  chk_stop_halt: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    stop_mode_i |=> !main_clk_en_o && !can_clk_en_o &&
                    !periph_clk_run_o)
    else $error("clock running in stop mode");
  chk_wdt_source: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 (wdt_src_oco_o == $past(protect_q[WDT_SRC_BIT])))
    else $error("watchdog source mismatch");
  chk_div_source: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    ##1 (div_clk_from_main_o == $past(protect_q[DIV_SRC_BIT])))
    else $error("divided clock source mismatch");
endmodule
`default_nettype wire

/* dv/tb_top.sv */
/*
  Self-checking testbench for the clock protect and main oscillator block.
  Assumes cpm_pkg and cpm_top are compiled first and one 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cpm_pkg::*;
  logic              clk_sys_i;
  logic              rstn_i;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              wr, rd, sub_en, stop_m, wait_m, main_osc_input_pin;
  logic              tk32, wsrc, oco, wblk, nmi, cut, dmain;
  logic              mrun, main_osc_output_pin, pllref, stk, prun, men, can;
  int                n_fail;
  int                n_tests;
  int                a;
  int                b;

  cpm_top i_cpm_top (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .sub_clk_en_i(sub_en),
    .stop_mode_i(stop_m), .wait_mode_i(wait_m),
    .main_osc_input_pin_i(main_osc_input_pin), .rdata_o(rdata), .sub_div32_tick_o(tk32),
    .wdt_src_oco_o(wsrc), .oco_run_o(oco), .wdt_stop_block_o(wblk),
    .nmi_enable_o(nmi), .motor_cutoff_en_o(cut),
    .div_clk_from_main_o(dmain), .main_osc_run_o(mrun),
    .main_osc_output_pin_o(main_osc_output_pin), .pll_ref_main_o(pllref),
    .cpu_self_osc_tick_o(stk), .periph_clk_run_o(prun),
    .main_clk_en_o(men), .can_clk_en_o(can));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task bus_wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys_i);
    wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task bus_rd(input logic [11:0] ad, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk_sys_i);
    rd   <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task settle;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task run(input int n, input logic en);
    repeat (n) begin
      @(posedge clk_sys_i);
      sub_en <= en;
      #1;
      a += tk32;
      b += stk;
    end
  endtask

  task t_reset;
    settle();
    check({mrun, men, can, prun, wsrc, nmi, pllref, main_osc_output_pin}, 8'hF1);
    bus_rd(PROTECT_OFS, 8'h00);
    bus_rd(OSC_CTRL_OFS, 8'h00);
    bus_rd(12'h000, 8'h00);
    b = 0;
    run(120, 1'b0);
    check(8'(b), 8'h0A);
  endtask

  task t_guard;
    bus_wr(PROTECT_OFS, 8'h54);
    bus_rd(PROTECT_OFS, 8'h00);
    bus_wr(WPROT_OFS, 8'h02);
    bus_wr(PROTECT_OFS, 8'h54);
    bus_rd(PROTECT_OFS, 8'h54);
    settle();
    check({2'b00, wsrc, oco, wblk, nmi, cut, dmain}, 8'h3F);
    bus_wr(PROTECT_OFS, 8'h00);
    bus_rd(PROTECT_OFS, 8'h14);
    settle();
    check({5'h00, wsrc, nmi, dmain}, 8'h06);
  endtask

  task t_osc;
    main_osc_input_pin <= 1'b1;
    bus_wr(OSC_CTRL_OFS, 8'h02);
    settle();
    check({6'h00, mrun, main_osc_output_pin}, 8'h01);
    bus_rd(OSC_CTRL_OFS, 8'h02);
    bus_wr(OSC_CTRL_OFS, 8'h04);
    settle();
    check({5'h00, mrun, main_osc_output_pin, pllref}, 8'h05);
    bus_wr(OSC_CTRL_OFS, 8'h00);
    bus_wr(PROTECT_OFS, 8'h02);
    bus_wr(OSC_CTRL_OFS, 8'h0F);
    bus_rd(OSC_CTRL_OFS, 8'h00);
    bus_wr(PROTECT_OFS, 8'h00);
    bus_rd(PROTECT_OFS, 8'h16);
  endtask

  // A clear in mid-count must restart the 32-edge period from zero.
  task t_presc;
    bus_wr(PRESCALER_OFS, 8'h80);
    bus_rd(PRESCALER_OFS, 8'h00);
    a = 0;
    run(20, 1'b1);
    run(1, 1'b0);
    bus_wr(PRESCALER_OFS, 8'h80);
    run(31, 1'b1);
    run(3, 1'b0);
    check(8'(a), 8'h00);
    run(1, 1'b1);
    run(3, 1'b0);
    check(8'(a), 8'h01);
    run(64, 1'b1);
    run(3, 1'b0);
    check(8'(a), 8'h03);
  endtask

  task t_stop;
    stop_m <= 1'b1;
    settle();
    check({4'h0, men, oco, prun, can}, 8'h00);
    b = 0;
    run(24, 1'b0);
    check(8'(b), 8'h00);
    stop_m <= 1'b0;
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    bus_rd(PROTECT_OFS, 8'h00);
  endtask

  initial begin
    {addr, wdata, wr, rd, sub_en, stop_m, wait_m, main_osc_input_pin} = '0;
    rstn_i  = 1'b0;
    n_fail  = 0;
    n_tests = 0;
    a       = 0;
    b       = 0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_guard();
    t_osc();
    t_presc();
    t_stop();
    test_done();
  end

  initial begin
    #900000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
